// ===== hw/tiv_pkg.sv
// Package for the triplex input voter: widths, encodings and carried structs
package tiv_pkg;
  localparam int unsigned NUM_CH = 16;
  localparam int unsigned NUM_BOARDS = 3;
  localparam logic [4:0] CHASSIS_MIN = 5'h01;
  localparam logic [4:0] CHASSIS_MAX = 5'h10;
  localparam logic [4:0] SLOT_MIN = 5'h01;
  localparam logic [4:0] SLOT_MAX = 5'h0a;
  localparam logic [15:0] DISAGREE_RST = 16'h0000;
  localparam logic [15:0] VOTED_RST = 16'h0000;
  localparam logic [2:0] FAULT_RST = 3'h7;

  // One board's placement on the remote bus
  typedef struct packed {
    logic [4:0] chassis;
    logic [4:0] slot;
  } tiv_place_t;

  // One board's sampled copy of all channels
  typedef struct packed {
    logic valid;
    logic fault;
    logic [NUM_CH-1:0] data;
  } tiv_copy_t;

  // Presentation of discrepancy results
  typedef enum logic {
    TIV_UNPACKED,
    TIV_PACKED
  } tiv_present_t;
endpackage

// ===== hw/tiv_voter.sv
// Triplex input voter: majority vote, board faults and per-channel discrepancy
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
// Operation
// - Three 16-channel board copies yield one voted value per channel.
// - Voted output is one when the voted input is high, zero when low.
// - Three fault flags, board one first; zero healthy, one faulty.
// - Channel disagreement flag set when any used copy differs from the others.
// - Disagreement flags are neither held nor filtered; latest vote only.
// - Unpacked form: sixteen flags, channel one first, channel sixteen last.
// - Packed form: one 16-bit word, channel one bit zero, sixteen bit fifteen.
// - Packed bit is one on disagreement, zero when all copies agree.
// - Multi-bit forms put channel one at bit zero, sixteen at bit fifteen.
// - Chassis and slot numbers count from one, never zero.
module tiv_voter (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [2:0] board_strobe,
  input wire logic [47:0] board_data,
  input wire logic [2:0] board_fault,
  input wire logic [4:0] controller_chassis_number,
  input wire logic [4:0] controller_slot_number,
  input wire logic [9:0] first_board_place,
  input wire logic [4:0] second_board_chassis,
  input wire logic [4:0] second_board_slot,
  input wire logic [4:0] third_board_chassis,
  input wire logic [4:0] third_board_slot,
  input wire logic present_packed,
  output logic [15:0] voted_q,
  output logic [2:0] board_fault_q,
  output logic [15:0] disagree_flags_q,
  output logic [15:0] disagree_word_q,
  output logic vote_done_q,
  output logic config_error_q
);

  ////////////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  logic [2:0] strobe_s1_q, strobe_s2_q, strobe_s3_q;
  logic [47:0] data_s1_q, data_s2_q;
  logic [2:0] fault_s1_q, fault_s2_q;
  logic present_s1_q, present_s2_q;
  // Placement numbers, controller first, then boards one to three
  logic [39:0] cfg_s1_q, cfg_s2_q;

  // Third stage only feeds the rising-edge detect
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      strobe_s1_q <= 3'h0;
      strobe_s2_q <= 3'h0;
      strobe_s3_q <= 3'h0;
    end else begin
      strobe_s1_q <= board_strobe;
      strobe_s2_q <= strobe_s1_q;
      strobe_s3_q <= strobe_s2_q;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      data_s1_q <= 48'h0;
      data_s2_q <= 48'h0;
    end else begin
      data_s1_q <= board_data;
      data_s2_q <= data_s1_q;
    end
  end

  // Boards count as faulty until a copy says otherwise
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fault_s1_q <= tiv_pkg::FAULT_RST;
      fault_s2_q <= tiv_pkg::FAULT_RST;
    end else begin
      fault_s1_q <= board_fault;
      fault_s2_q <= fault_s1_q;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      present_s1_q <= 1'b0;
      present_s2_q <= 1'b0;
    end else begin
      present_s1_q <= present_packed;
      present_s2_q <= present_s1_q;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_s1_q <= 40'h0;
      cfg_s2_q <= 40'h0;
    end else begin
      cfg_s1_q <= {controller_chassis_number, controller_slot_number, first_board_place,
                   second_board_chassis, second_board_slot, third_board_chassis, third_board_slot};
      cfg_s2_q <= cfg_s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Per-board copy capture
  tiv_pkg::tiv_copy_t copy_q [3];
  logic [2:0] new_copy;

  assign new_copy = strobe_s2_q & ~strobe_s3_q;

  genvar b;
  generate
    for (b = 0; b < 3; b++) begin : g_copy
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          copy_q[b] <= '0;
        end else if (new_copy[b]) begin
          copy_q[b].valid <= 1'b1;
          copy_q[b].fault <= fault_s2_q[b];
          copy_q[b].data <= data_s2_q[b*16 +: 16];
        end else if (vote_done_q) begin
          copy_q[b].valid <= 1'b0;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // Vote
  function automatic logic [15:0] majority(input logic [15:0] a, input logic [15:0] b2, input logic [15:0] c);
    majority = (a & b2) | (a & c) | (b2 & c);
  endfunction

  function automatic logic [15:0] differ(input logic [15:0] a, input logic [15:0] b2, input logic [15:0] c);
    differ = (a ^ b2) | (a ^ c);
  endfunction

  function automatic logic place_ok(input logic [4:0] ch, input logic [4:0] sl);
    place_ok = (ch >= tiv_pkg::CHASSIS_MIN) && (ch <= tiv_pkg::CHASSIS_MAX) &&
               (sl >= tiv_pkg::SLOT_MIN) && (sl <= tiv_pkg::SLOT_MAX);
  endfunction

  logic vote_now;
  logic [15:0] vote_d;
  logic [15:0] diff_d;
  assign vote_now = copy_q[0].valid && copy_q[1].valid && copy_q[2].valid && !vote_done_q;
  assign vote_d = majority(copy_q[0].data, copy_q[1].data, copy_q[2].data);
  assign diff_d = differ(copy_q[0].data, copy_q[1].data, copy_q[2].data);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      vote_done_q <= 1'b0;
    end else begin
      vote_done_q <= vote_now;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      voted_q <= tiv_pkg::VOTED_RST;
    end else if (vote_now) begin
      voted_q <= vote_d;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      board_fault_q <= tiv_pkg::FAULT_RST;
    end else if (vote_now) begin
      board_fault_q <= {copy_q[2].fault, copy_q[1].fault, copy_q[0].fault};
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Discrepancy presentation
  // Fresh each vote, no latching; each vote writes zero to the unused form
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      disagree_flags_q <= tiv_pkg::DISAGREE_RST;
    end else if (vote_now) begin
      if (present_s2_q == tiv_pkg::TIV_PACKED) begin
        disagree_flags_q <= tiv_pkg::DISAGREE_RST;
      end else begin
        disagree_flags_q <= diff_d;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      disagree_word_q <= tiv_pkg::DISAGREE_RST;
    end else if (vote_now) begin
      if (present_s2_q == tiv_pkg::TIV_PACKED) begin
        disagree_word_q <= diff_d;
      end else begin
        disagree_word_q <= tiv_pkg::DISAGREE_RST;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Placement check; zero is never a legal number
  tiv_pkg::tiv_place_t place [3];
  logic [2:0] place_good;

  genvar p;
  generate
    for (p = 0; p < 3; p++) begin : g_place
      assign place[p] = cfg_s2_q[29-10*p -: 10];
      assign place_good[p] = place_ok(place[p].chassis, place[p].slot);
    end
  endgenerate

  // Advisory only; voting goes on regardless
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      config_error_q <= 1'b0;
    end else begin
      config_error_q <= !((&place_good) && (cfg_s2_q[39:35] != 5'h00) && (cfg_s2_q[34:30] != 5'h00));
    end
  end

endmodule

// ===== bench/tiv_boards.sv
// Model of the three redundant input boards
`timescale 1ns/100ps
module tiv_boards (
  input wire logic clk,
  input wire logic go,
  input wire logic [2:0] lag,
  input wire logic [47:0] copy,
  input wire logic [2:0] bad,
  output logic [2:0] board_strobe,
  output logic [47:0] board_data,
  output logic [2:0] board_fault
);
  logic run_q;
  // Copy leads strobe; released data and fault lines toggle, strobes clear
  always_ff @(posedge clk) begin
    run_q <= go;
    board_data <= go ? copy : ~board_data;
    board_fault <= go ? bad : ~board_fault;
    board_strobe <= run_q ? ~lag | board_strobe | {3{|board_strobe}} : 3'h0;
  end
endmodule

// ===== bench/tiv_voter_sva.sv
// Voter port checker
`timescale 1ns/100ps
module tiv_voter_sva (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [2:0] board_strobe,
  input wire logic [47:0] board_data,
  input wire logic [2:0] board_fault,
  input wire logic present_packed,
  input wire logic [15:0] voted_q,
  input wire logic [2:0] board_fault_q,
  input wire logic [15:0] disagree_flags_q,
  input wire logic [15:0] disagree_word_q,
  input wire logic vote_done_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire logic v = vote_done_q, p = present_packed;
  wire logic [15:0] a = board_data[15:0], b = board_data[31:16], c = board_data[47:32];
  wire logic [15:0] mj = (a & b) | (a & c) | (b & c), ds = (a ^ b) | (a ^ c);
  sequence s_up; board_strobe == 3'h7 && $past(board_strobe) == 3'h0; endsequence
  sequence s_wait; !v [*4] ##1 v; endsequence
  a_vote_late: assert property (s_up |-> s_wait) else $error("vote late");
  a_done_once: assert property (v |=> !v) else $error("done long");
  a_vote_major: assert property (v |-> voted_q == $past(mj, 2)) else $error("vote");
  a_fault_copy: assert property (v |-> board_fault_q == $past(board_fault, 2)) else $error("fault");
  a_flags_live: assert property (v && !p |-> disagree_flags_q == $past(ds, 2)) else $error("flags");
  a_word_live: assert property (v && p |-> disagree_word_q == $past(ds, 2)) else $error("word");
  a_unused_zero: assert property (v |-> (p ? disagree_flags_q : disagree_word_q) == 16'h0000) else $error("zero");
  a_result_stand: assert property (!v |-> $stable(voted_q) && $stable(board_fault_q)) else $error("moved");
endmodule

// ===== bench/testbench.sv
// Self-checking bench for the triplex voter
`timescale 1ns/100ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin failures++; $display("BAD %0t %h", $time, g); end end
module testbench;
  logic clk = 1'b0, rst_n = 1'b0, go = 1'b0, present_packed = 1'b0, vote_done_q, config_error_q;
  logic [2:0] lag = 3'h0, bad = 3'h0, board_strobe, board_fault, board_fault_q;
  logic [47:0] cp = 48'h0, board_data;
  logic [15:0] voted_q, disagree_flags_q, disagree_word_q;
  logic [39:0] cfg = 40'h0842182843;
  int seed = 32'ha028e2c4, failures = 0, n_checks = 0;
  tiv_voter tiv_voter_i (.clk, .rst_n, .board_strobe, .board_data, .board_fault, .controller_chassis_number(cfg[39:35]),
    .controller_slot_number(cfg[34:30]), .first_board_place(cfg[29:20]), .second_board_chassis(cfg[19:15]),
    .second_board_slot(cfg[14:10]), .third_board_chassis(cfg[9:5]), .third_board_slot(cfg[4:0]), .present_packed,
    .voted_q, .board_fault_q, .disagree_flags_q, .disagree_word_q, .vote_done_q, .config_error_q);
  tiv_boards tiv_boards_i (.clk, .go, .lag, .copy(cp), .bad, .board_strobe, .board_data, .board_fault);
  initial forever #50 clk = ~clk;
  function automatic logic [31:0] ex(logic [47:0] c);
    ex = {(c[15:0] ^ c[31:16]) | (c[15:0] ^ c[47:32]),
      (c[15:0] & c[31:16]) | (c[15:0] & c[47:32]) | (c[31:16] & c[47:32])};
  endfunction
  function automatic logic cb(logic [39:0] c);
    cb = c[39:35] == 5'h00 || c[34:30] == 5'h00;
    for (int i = 0; i < 3; i++) cb |= !(c[29-10*i-:5] inside {[1:16]}) || !(c[24-10*i-:5] inside {[1:10]});
  endfunction
  task automatic vote(logic [47:0] c, logic [2:0] f, logic [2:0] l);
    int k;
    k = 0;
    if (l == 3'h7) l = 3'h0;
    cp <= c;
    bad <= f;
    lag <= l;
    go <= 1'b1;
    do begin @(posedge clk); k++; end while (vote_done_q !== 1'b1 && k < 20);
    go <= 1'b0;
    `CHK(k, l ? 8 : 7)
    `CHK(voted_q, ex(c) & 32'hffff)
    `CHK(board_fault_q, f)
    `CHK(disagree_flags_q, present_packed ? 16'h0000 : ex(c) >> 16)
    `CHK(disagree_word_q, present_packed ? ex(c) >> 16 : 16'h0000)
    repeat (3) @(posedge clk);
  endtask
  task automatic stop_test;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    #1000000;
    failures++;
    stop_test();
  end
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    for (int m = 0; m < 2; m++) begin
      present_packed <= m[0];
      repeat (4) @(posedge clk);
      vote(48'h0, 3'h0, 3'h0);
      vote(48'h000000010000, 3'h1, 3'h0);
      vote(48'h800000000000, 3'h4, 3'h1);
      vote(48'h7fff80008000, 3'h2, 3'h6);
      repeat (12) vote(48'({$random(seed), $random(seed)}), 3'($random(seed)), 3'($random(seed)));
      $display("mode %0d done", m);
    end
    for (int i = 0; i < 8; i++) begin
      repeat (4) @(posedge clk);
      `CHK(config_error_q, cb(cfg))
      cfg <= cfg ^ (40'h1 << ($unsigned($random(seed)) % 40));
    end
    $display("config done");
    stop_test();
  end
endmodule
bind tiv_voter tiv_voter_sva tiv_voter_sva_i (.*);
